// ### design/cpr_defs.svh
// Purpose: Addresses, field positions and reset values of the pin routing block
// Assumes: 8-bit register space reached over the codec's internal register port
// Notes: Included by the routing module
`ifndef CPR_DEFS_SVH
`define CPR_DEFS_SVH

`define CPR_ADDR_W 8
`define CPR_DATA_W 8

`define CPR_ADDR_SEC_IN 8'h12
`define CPR_ADDR_MIC 8'h13
`define CPR_ADDR_PWR 8'h14
`define CPR_ADDR_BIAS 8'h15
`define CPR_ADDR_PORT0 8'h18

`define CPR_RST_SEC_IN 8'h00
`define CPR_RST_MIC 8'h00
`define CPR_RST_PWR 8'h00
`define CPR_RST_BIAS 8'h00
`define CPR_RST_PORT0 8'h40

// Writable bits; the rest are reserved and read as zero
`define CPR_MASK_SEC_IN 8'hfc
`define CPR_MASK_BIAS 8'hf0

// Three-bit source codes of the secondary port inputs
`define CPR_SRC_OFF 3'h0
`define CPR_SRC_GP1 3'h1
`define CPR_SRC_GP2 3'h2
`define CPR_SRC_GI1 3'h3
`define CPR_SRC_DOUT 3'h4
`define CPR_SRC_PDIN 3'h5

// Two-bit pin codes
`define CPR_PIN_OFF 2'h0
`define CPR_PIN_GP1 2'h1
`define CPR_PIN_GP2 2'h2
`define CPR_PIN_GI1 2'h3

`endif

// ### design/cpr_pkg.sv
// Purpose: Types shared by the pin routing block
// Assumes: Field layouts follow cpr_defs.svh
// Notes: Registers are carried as packed structs
package cpr_pkg;

    typedef struct packed {
        logic [2:0] second_port_input_one_source;
        logic [2:0] second_port_input_two_source;
        logic [1:0] rsvd;
    } cpr_sec_in_t;

    typedef struct packed {
        logic record_ch1_type;
        logic record_ch2_type;
        logic mic_pair_a_edge;
        logic mic_pair_b_edge;
        logic [1:0] mic_pair_a_source;
        logic [1:0] mic_pair_b_source;
    } cpr_mic_t;

    typedef struct packed {
        logic mic_source_override;
        logic dout_shared;
        logic [1:0] record_conv_off_pin;
        logic [1:0] playback_conv_off_pin;
        logic limiter_pin_control;
        logic aux_function_pin_control;
    } cpr_pwr_t;

    typedef struct packed {
        logic [1:0] mic_bias_pin_enable;
        logic [1:0] aux_conv_start_pin;
        logic [3:0] rsvd;
    } cpr_bias_t;

    typedef struct packed {
        logic primary_disable;
        logic secondary_disable;
        logic [5:0] other;
    } cpr_port0_t;

    // Pin levels, before and after synchronisation
    typedef struct packed {
        logic general_pin_one;
        logic general_pin_two;
        logic input_only_pin_one;
        logic serial_din;
        logic serial_dout;
        logic microphone_clock;
        logic mic_data;
    } cpr_pins_t;

endpackage

// ### design/cpr_pin_routing.sv
// Purpose: Pin routing and pin-control configuration of the stereo codec
// Assumes: All pin inputs are asynchronous to ref_clk_i; mic clock well below 5 MHz
// Notes: Microphone sampling detects clock edges after synchronisation
`timescale 1ns/100ps
`include "cpr_defs.svh"

// Functional notes
// RULE_01 - 0x12 bits 7-5 pick the secondary input one source.
// RULE_02 - 0x12 bits 4-2 pick secondary input two, same codes.
// RULE_03 - 0x12 bits 1-0 read zero; software writes zero.
// RULE_04 - 0x13 bits 7, 6 make record channels 1, 2 microphone type.
// RULE_05 - Bit 5 of 0x13 swaps the latching edges of channels 1 and 2.
// RULE_06 - Bit 4 of 0x13 swaps the latching edges of channels 3 and 4.
// RULE_07 - Bits 3-2 of 0x13 pick the data pin for microphone channels 1 and 2.
// RULE_08 - Bits 1-0 of 0x13 pick the data pin for channels 3 and 4.
// RULE_09 - Bit 7 of 0x14 replaces input-only pin one by serial data input; applied to the microphone data pin choice only.
// RULE_10 - Bit 6 of 0x14 makes the output pin also the serial data input.
// RULE_11 - 0x14 bits 5-4 pick a record power-down pin, ORed with register.
// RULE_12 - 0x14 bits 3-2 pick a playback power-down pin, ORed likewise.
// RULE_13 - Bit 1 of 0x14 drives the limiter function from general pin one.
// RULE_14 - Bit 0 of 0x14 drives the auxiliary function from general pin one.
// RULE_15 - Bits 7-6 of 0x15 pick a pin enabling the microphone bias supply.
// RULE_16 - Bits 5-4 of 0x15 pick a conversion start pin; bits 3-0 read zero.
// RULE_17 - Normally the output pin carries primary port transmit data.
// RULE_18 - Every pin input is synchronised before any use.
module cpr_pin_routing (
    input wire logic ref_clk_i, // 10 MHz clock
    input wire logic rst_i, // Async reset, active high
    input wire logic [`CPR_ADDR_W-1:0] reg_addr_i, // Register address
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    input wire logic [`CPR_DATA_W-1:0] reg_wdata_i, // Write data
    output logic [`CPR_DATA_W-1:0] reg_rdata_o, // Read data
    input wire logic general_pin_one_i, // Pin level
    input wire logic general_pin_two_i, // Pin level
    input wire logic input_only_pin_one_i, // Pin level
    input wire logic serial_din_i, // Primary data input pin
    input wire logic microphone_clock_i, // Microphone clock pin
    input wire logic serial_dout_i, // Output pin, input side
    output logic serial_dout_o, // Output pin, driven value
    output logic serial_dout_oe_n_o, // Output pin enable, low drives
    input wire logic primary_dout_i, // Primary port transmit data
    input wire logic record_conv_power_ctrl_i, // 1 = keep converter on
    input wire logic playback_conv_power_ctrl_i, // 1 = keep converter on
    output logic primary_din_o, // Primary port receive data
    output logic second_port_din1_o, // Secondary port input one
    output logic second_port_din2_o, // Secondary port input two
    output logic record_ch1_digital_o, // Channel 1 microphone type
    output logic record_ch2_digital_o, // Channel 2 microphone type
    output logic [3:0] mic_data_o, // Latched bits, ch1..ch4
    output logic [3:0] mic_strobe_o, // Pulse per new bit
    output logic record_conv_off_o, // Record converter off
    output logic playback_conv_off_o, // Playback converter off
    output logic limiter_ctrl_o, // Limiter control
    output logic aux_function_ctrl_o, // Auxiliary function control
    output logic mic_bias_en_o, // Bias supply enable
    output logic aux_conv_start_o // Conversion start pulse
);

    function automatic logic pick_pin(input logic [1:0] code, input cpr_pkg::cpr_pins_t p,
                                      input logic ovrd);
        logic v;
        v = 1'b0;
        unique case (code)
            `CPR_PIN_OFF: v = 1'b0;
            `CPR_PIN_GP1: v = p.general_pin_one;
            `CPR_PIN_GP2: v = p.general_pin_two;
            `CPR_PIN_GI1: v = ovrd ? p.serial_din : p.input_only_pin_one; // RULE_09
        endcase
        return v;
    endfunction

    // Reserved codes 6 and 7 give a quiet low input
    function automatic logic pick_src(input logic [2:0] code, input cpr_pkg::cpr_pins_t p,
                                      input logic pdin);
        logic v;
        v = 1'b0;
        case (code)
            `CPR_SRC_GP1: v = p.general_pin_one;
            `CPR_SRC_GP2: v = p.general_pin_two;
            `CPR_SRC_GI1: v = p.input_only_pin_one;
            `CPR_SRC_DOUT: v = p.serial_dout;
            `CPR_SRC_PDIN: v = pdin;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // Register group
    cpr_pkg::cpr_sec_in_t sec_in_reg, sec_in_next;
    cpr_pkg::cpr_mic_t mic_reg, mic_next;
    cpr_pkg::cpr_pwr_t pwr_reg, pwr_next;
    cpr_pkg::cpr_bias_t bias_reg, bias_next;
    cpr_pkg::cpr_port0_t port0_reg, port0_next;
    logic [`CPR_DATA_W-1:0] rdata_reg, rdata_next;

    always_comb
    begin
        sec_in_next = sec_in_reg;
        mic_next = mic_reg;
        pwr_next = pwr_reg;
        bias_next = bias_reg;
        port0_next = port0_reg;
        rdata_next = rdata_reg;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `CPR_ADDR_SEC_IN: sec_in_next = reg_wdata_i & `CPR_MASK_SEC_IN; // RULE_03
                `CPR_ADDR_MIC: mic_next = reg_wdata_i;
                `CPR_ADDR_PWR: pwr_next = reg_wdata_i;
                `CPR_ADDR_BIAS: bias_next = reg_wdata_i & `CPR_MASK_BIAS; // RULE_16
                `CPR_ADDR_PORT0: port0_next = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `CPR_ADDR_SEC_IN: rdata_next = sec_in_reg;
                `CPR_ADDR_MIC: rdata_next = mic_reg;
                `CPR_ADDR_PWR: rdata_next = pwr_reg;
                `CPR_ADDR_BIAS: rdata_next = bias_reg;
                `CPR_ADDR_PORT0: rdata_next = port0_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sec_in_reg <= `CPR_RST_SEC_IN;
            mic_reg <= `CPR_RST_MIC;
            pwr_reg <= `CPR_RST_PWR;
            bias_reg <= `CPR_RST_BIAS;
            port0_reg <= `CPR_RST_PORT0;
            rdata_reg <= '0;
        end
        else
        begin
            sec_in_reg <= sec_in_next;
            mic_reg <= mic_next;
            pwr_reg <= pwr_next;
            bias_reg <= bias_next;
            port0_reg <= port0_next;
            rdata_reg <= rdata_next;
        end
    end

    // Two-stage synchronisers; logic reads the second stage and its one-cycle delayed copy prev_reg
    cpr_pkg::cpr_pins_t meta_reg, sync_reg, prev_reg;
    cpr_pkg::cpr_pins_t raw;

    always_comb
    begin
        raw.general_pin_one = general_pin_one_i;
        raw.general_pin_two = general_pin_two_i;
        raw.input_only_pin_one = input_only_pin_one_i;
        raw.serial_din = serial_din_i;
        raw.serial_dout = serial_dout_i;
        raw.microphone_clock = microphone_clock_i;
        raw.mic_data = 1'b0;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            meta_reg <= raw; // RULE_18
            sync_reg <= meta_reg; // RULE_18
            prev_reg <= sync_reg;
        end
    end

    // Routing and control outputs
    logic pdin, pdin_next, pdin_reg;
    logic din1_next, din1_reg, din2_next, din2_reg;
    logic dout_next, dout_reg, oe_n_next, oe_n_reg;
    logic ch1_next, ch1_reg, ch2_next, ch2_reg;
    logic [3:0] mic_next_d, mic_d_reg, stb_next, stb_reg;
    logic rec_off_next, rec_off_reg, pb_off_next, pb_off_reg;
    logic lim_next, lim_reg, aux_next, aux_reg;
    logic bias_en_next, bias_en_reg, start_next, start_reg;
    logic mic_a, mic_b, rise, fall, start_now, start_prev;

    always_comb
    begin
        // Shared mode takes receive data from the output pin
        pdin = pwr_reg.dout_shared ? sync_reg.serial_dout : sync_reg.serial_din; // RULE_10
        pdin_next = port0_reg.primary_disable ? 1'b0 : pdin;
        din1_next = 1'b0;
        din2_next = 1'b0;
        if (!port0_reg.secondary_disable)
        begin
            din1_next = pick_src(sec_in_reg.second_port_input_one_source, sync_reg, pdin); // RULE_01
            din2_next = pick_src(sec_in_reg.second_port_input_two_source, sync_reg, pdin); // RULE_02
        end
        // Output pin keeps its primary transmit role, also in shared mode
        dout_next = primary_dout_i; // RULE_17
        oe_n_next = port0_reg.primary_disable;
        ch1_next = mic_reg.record_ch1_type; // RULE_04
        ch2_next = mic_reg.record_ch2_type; // RULE_04

        mic_a = pick_pin(mic_reg.mic_pair_a_source, sync_reg, pwr_reg.mic_source_override); // RULE_07
        mic_b = pick_pin(mic_reg.mic_pair_b_source, sync_reg, pwr_reg.mic_source_override); // RULE_08
        rise = sync_reg.microphone_clock & ~prev_reg.microphone_clock;
        fall = ~sync_reg.microphone_clock & prev_reg.microphone_clock;
        // Data is sampled with the same two-stage delay as the clock, so phases match
        stb_next[0] = (mic_reg.mic_pair_a_source != `CPR_PIN_OFF) &
                      (mic_reg.mic_pair_a_edge ? rise : fall); // RULE_05
        stb_next[1] = (mic_reg.mic_pair_a_source != `CPR_PIN_OFF) &
                      (mic_reg.mic_pair_a_edge ? fall : rise); // RULE_05
        stb_next[2] = (mic_reg.mic_pair_b_source != `CPR_PIN_OFF) &
                      (mic_reg.mic_pair_b_edge ? rise : fall); // RULE_06
        stb_next[3] = (mic_reg.mic_pair_b_source != `CPR_PIN_OFF) &
                      (mic_reg.mic_pair_b_edge ? fall : rise); // RULE_06
        mic_next_d[0] = stb_next[0] ? mic_a : mic_d_reg[0];
        mic_next_d[1] = stb_next[1] ? mic_a : mic_d_reg[1];
        mic_next_d[2] = stb_next[2] ? mic_b : mic_d_reg[2];
        mic_next_d[3] = stb_next[3] ? mic_b : mic_d_reg[3];

        rec_off_next = ~record_conv_power_ctrl_i |
                       pick_pin(pwr_reg.record_conv_off_pin, sync_reg, 1'b0); // RULE_11
        pb_off_next = ~playback_conv_power_ctrl_i |
                      pick_pin(pwr_reg.playback_conv_off_pin, sync_reg, 1'b0); // RULE_12
        lim_next = pwr_reg.limiter_pin_control & sync_reg.general_pin_one; // RULE_13
        aux_next = pwr_reg.aux_function_pin_control & sync_reg.general_pin_one; // RULE_14
        bias_en_next = pick_pin(bias_reg.mic_bias_pin_enable, sync_reg, 1'b0); // RULE_15
        // A start is the rising edge of the chosen pin, so a held level starts once
        start_now = pick_pin(bias_reg.aux_conv_start_pin, sync_reg, 1'b0); // RULE_16
        start_prev = pick_pin(bias_reg.aux_conv_start_pin, prev_reg, 1'b0);
        start_next = start_now & ~start_prev;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pdin_reg <= 1'b0;
            din1_reg <= 1'b0;
            din2_reg <= 1'b0;
            dout_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            ch1_reg <= 1'b0;
            ch2_reg <= 1'b0;
            mic_d_reg <= 4'h0;
            stb_reg <= 4'h0;
            rec_off_reg <= 1'b1;
            pb_off_reg <= 1'b1;
            lim_reg <= 1'b0;
            aux_reg <= 1'b0;
            bias_en_reg <= 1'b0;
            start_reg <= 1'b0;
        end
        else
        begin
            pdin_reg <= pdin_next;
            din1_reg <= din1_next;
            din2_reg <= din2_next;
            dout_reg <= dout_next;
            oe_n_reg <= oe_n_next;
            ch1_reg <= ch1_next;
            ch2_reg <= ch2_next;
            mic_d_reg <= mic_next_d;
            stb_reg <= stb_next;
            rec_off_reg <= rec_off_next;
            pb_off_reg <= pb_off_next;
            lim_reg <= lim_next;
            aux_reg <= aux_next;
            bias_en_reg <= bias_en_next;
            start_reg <= start_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign primary_din_o = pdin_reg;
    assign second_port_din1_o = din1_reg;
    assign second_port_din2_o = din2_reg;
    assign serial_dout_o = dout_reg;
    assign serial_dout_oe_n_o = oe_n_reg;
    assign record_ch1_digital_o = ch1_reg;
    assign record_ch2_digital_o = ch2_reg;
    assign mic_data_o = mic_d_reg;
    assign mic_strobe_o = stb_reg;
    assign record_conv_off_o = rec_off_reg;
    assign playback_conv_off_o = pb_off_reg;
    assign limiter_ctrl_o = lim_reg;
    assign aux_function_ctrl_o = aux_reg;
    assign mic_bias_en_o = bias_en_reg;
    assign aux_conv_start_o = start_reg;

endmodule // cpr_pin_routing

// ### verif/cpr_pin_routing_properties.sv
// Purpose: Port-level properties of the pin routing block
// Assumes: Only strobe-port writes change configuration
// Notes: Shadows written registers
`timescale 1ns/100ps
module cpr_pin_routing_properties (
    input wire logic ref_clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic [7:0] reg_addr_i, // Address
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic [7:0] reg_rdata_o, // Read data
    input wire logic general_pin_one_i, // Pin
    input wire logic general_pin_two_i, // Pin
    input wire logic record_conv_power_ctrl_i, // Keep record on
    input wire logic playback_conv_power_ctrl_i, // Keep playback on
    input wire logic record_ch1_digital_o, // Channel 1 type
    input wire logic [3:0] mic_strobe_o, // Mic strobes
    input wire logic record_conv_off_o, // Record off
    input wire logic playback_conv_off_o, // Playback off
    input wire logic limiter_ctrl_o, // Limiter
    input wire logic mic_bias_en_o, // Bias enable
    input wire logic aux_conv_start_o // Conversion start
);
    // Bytes of 0x13, 0x14, 0x15
    logic [23:0] sh_reg;
    logic [23:0] sh_next;
    always_comb
    begin
        sh_next = sh_reg;
        if (reg_wr_i && reg_addr_i == 8'h13) sh_next[23:16] = reg_wdata_i;
        if (reg_wr_i && reg_addr_i == 8'h14) sh_next[15:8] = reg_wdata_i;
        if (reg_wr_i && reg_addr_i == 8'h15) sh_next[7:0] = reg_wdata_i;
    end
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            sh_reg <= 24'h000000;
        else
            sh_reg <= sh_next;
    end
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    rsvd_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h12 |=> !reg_rdata_o[1:0])
        else $error("0x12 reserved bits nonzero");
    bias_rsvd_a: assert property (reg_rd_i && reg_addr_i == 8'h15 |=> !reg_rdata_o[3:0])
        else $error("0x15 reserved bits nonzero");
    ch_type_a: assert property (record_ch1_digital_o == $past(sh_reg[23]))
        else $error("channel 1 type wrong");
    rec_off_pin_a: assert property ((sh_reg[13:12] == 2'h1 && record_conv_power_ctrl_i)[*4]
        |-> record_conv_off_o == $past(general_pin_one_i, 3))
        else $error("record off not following pin");
    play_off_reg_a: assert property ((!playback_conv_power_ctrl_i)[*4] |-> playback_conv_off_o)
        else $error("playback on against control");
    limiter_pin_a: assert property (sh_reg[9] [*4] |-> limiter_ctrl_o == $past(general_pin_one_i, 3))
        else $error("limiter not following pin");
    bias_pin_a: assert property ((sh_reg[7:6] == 2'h2)[*4]
        |-> mic_bias_en_o == $past(general_pin_two_i, 3))
        else $error("bias not following pin");
    conv_start_a: assert property ((sh_reg[5:4] == 2'h1)[*5] |-> aux_conv_start_o ==
        ($past(general_pin_one_i, 3) && !$past(general_pin_one_i, 4)))
        else $error("start not a pin rising edge");
    strobe_pulse_a: assert property (mic_strobe_o[0] |=> !mic_strobe_o[0])
        else $error("strobe too long");
    cover property (aux_conv_start_o);
    cover property (mic_strobe_o[1] && mic_strobe_o[3]);
    cover property (record_conv_off_o && record_conv_power_ctrl_i);
endmodule // cpr_pin_routing_properties

bind cpr_pin_routing cpr_pin_routing_properties cpr_pin_routing_properties_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .general_pin_one_i(general_pin_one_i), .general_pin_two_i(general_pin_two_i),
    .record_conv_power_ctrl_i(record_conv_power_ctrl_i),
    .playback_conv_power_ctrl_i(playback_conv_power_ctrl_i),
    .record_ch1_digital_o(record_ch1_digital_o), .mic_strobe_o(mic_strobe_o),
    .record_conv_off_o(record_conv_off_o), .playback_conv_off_o(playback_conv_off_o),
    .limiter_ctrl_o(limiter_ctrl_o), .mic_bias_en_o(mic_bias_en_o),
    .aux_conv_start_o(aux_conv_start_o));

// ### verif/cpr_pin_model.sv
// Purpose: Far-side pins and a pulse-density microphone
// Assumes: Microphone clock runs only while run_i is high, four cycles each level
// Notes: Data sits stable two cycles either side of each microphone clock edge
`timescale 1ns/100ps
module cpr_pin_model (
    input wire logic ref_clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic run_i, // Microphone active
    input wire logic fall_bit_i, // Bit for falling edges
    input wire logic rise_bit_i, // Bit for rising edges
    input wire cpr_pkg::cpr_pins_t cmd_i, // Pin levels wanted
    output cpr_pkg::cpr_pins_t pins_o // Pin levels
);
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    always_comb
    begin
        cnt_next = run_i ? cnt_reg + 3'h1 : 3'h0;
    end
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_reg <= 3'h0;
        else
            cnt_reg <= cnt_next;
    end
    // Clock stands low between bursts; data drives two pins so override can be seen
    always_comb
    begin
        pins_o = cmd_i;
        pins_o.microphone_clock = run_i && !cnt_reg[2];
        if (run_i)
        begin
            pins_o.mic_data = (cnt_reg[2] ^ cnt_reg[1]) ? fall_bit_i : rise_bit_i;
            pins_o.general_pin_two = pins_o.mic_data;
            pins_o.serial_din = pins_o.mic_data;
        end
    end
endmodule // cpr_pin_model

// ### verif/cpr_pin_routing_tb.sv
// Purpose: Self-checking bench of the pin routing block
// Assumes: Outputs settle within six clocks of a change
// Notes: Expected values come from field encodings
`timescale 1ns/100ps
module cpr_pin_routing_tb;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic primary_dout_i = 1'b0;
    logic rec_on = 1'b1;
    logic play_on = 1'b1;
    logic run = 1'b0;
    logic fall_bit = 1'b1;
    logic rise_bit = 1'b0;
    cpr_pkg::cpr_pins_t cmd = '0;
    cpr_pkg::cpr_pins_t pins;
    logic [7:0] reg_rdata_o;
    logic dout, oe_n, dout_wire, pdin, din1, din2, ch1, ch2;
    logic [3:0] mdata, mstb;
    logic rec_off, play_off, lim, auxf, bias, conv;
    int errors = 0;
    int compares = 0;
    logic [7:0] adr [6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h16};
    logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
    logic [7:0] msk [6] = '{8'hfc, 8'hff, 8'hff, 8'hf0, 8'hff, 8'h00};
    // Design wins the pin while it drives
    assign dout_wire = oe_n ? pins.serial_dout : dout;
    always #50 ref_clk_i = ~ref_clk_i;
    cpr_pin_model cpr_pin_model_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .run_i(run),
        .fall_bit_i(fall_bit), .rise_bit_i(rise_bit), .cmd_i(cmd), .pins_o(pins));
    cpr_pin_routing cpr_pin_routing_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .general_pin_one_i(pins.general_pin_one), .general_pin_two_i(pins.general_pin_two),
        .input_only_pin_one_i(pins.input_only_pin_one), .serial_din_i(pins.serial_din),
        .microphone_clock_i(pins.microphone_clock), .serial_dout_i(dout_wire),
        .serial_dout_o(dout), .serial_dout_oe_n_o(oe_n), .primary_dout_i(primary_dout_i),
        .record_conv_power_ctrl_i(rec_on), .playback_conv_power_ctrl_i(play_on),
        .primary_din_o(pdin), .second_port_din1_o(din1), .second_port_din2_o(din2),
        .record_ch1_digital_o(ch1), .record_ch2_digital_o(ch2), .mic_data_o(mdata),
        .mic_strobe_o(mstb), .record_conv_off_o(rec_off), .playback_conv_off_o(play_off),
        .limiter_ctrl_o(lim), .aux_function_ctrl_o(auxf), .mic_bias_en_o(bias),
        .aux_conv_start_o(conv));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check("register read", reg_rdata_o, e);
    endtask
    // Last bit of each channel over five mic clock periods
    task automatic mic(input logic [3:0] e, input logic [3:0] s);
        logic [3:0] got, seen;
        got = 4'h0;
        seen = 4'h0;
        @(posedge ref_clk_i);
        run <= 1'b1;
        settle(40);
        repeat (40)
        begin
            @(posedge ref_clk_i);
            #1;
            got = (got & ~mstb) | (mdata & mstb);
            seen = seen | mstb;
        end
        @(posedge ref_clk_i);
        run <= 1'b0;
        check("mic bits", got, e);
        check("mic strobes", seen, s);
    endtask
    function automatic logic src(input logic [2:0] c, input cpr_pkg::cpr_pins_t p,
        input logic w);
        case (c)
            3'h1: return p.general_pin_one;
            3'h2: return p.general_pin_two;
            3'h3: return p.input_only_pin_one;
            3'h4: return w;
            3'h5: return p.serial_din;
            default: return 1'b0;
        endcase
    endfunction
    initial
    begin
        logic [7:0] n;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        foreach (adr[i]) rc(adr[i], rstv[i]);
        foreach (adr[i])
        begin
            wr(adr[i], adr[i] == 8'h12 ? 8'hfc : 8'hff);
            rc(adr[i], msk[i]);
        end
        wr(8'h18, 8'h00);
        wr(8'h14, 8'h00);
        wr(8'h13, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h12, {c[2:0], 3'(7 - c), 2'h0});
            for (int k = 0; k < 2; k++)
            begin
                @(posedge ref_clk_i);
                cmd <= k ? 7'h28 : 7'h50;
                primary_dout_i <= k[0];
                settle(6);
                check("input one", din1, src(c[2:0], cmd, primary_dout_i));
                check("input two", din2, src(3'(7 - c), cmd, primary_dout_i));
            end
        end
        wr(8'h14, 8'h40);
        @(posedge ref_clk_i);
        cmd <= 7'h00;
        primary_dout_i <= 1'b1;
        settle(6);
        check("primary input", pdin, 8'h01);
        check("output pin", {oe_n, dout}, 8'h01);
        wr(8'h14, 8'h00);
        settle(6);
        check("primary input", pdin, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h14, {2'h0, s[1:0], s[1:0], 2'h3});
            wr(8'h15, {s[1:0], s[1:0], 4'h0});
            for (int k = 0; k < 2; k++)
            begin
                @(posedge ref_clk_i);
                cmd <= k ? 7'h50 : 7'h28;
                settle(6);
                check("record off", rec_off, src(3'(s), cmd, 1'b0));
                check("playback off", play_off, src(3'(s), cmd, 1'b0));
                check("bias enable", bias, src(3'(s), cmd, 1'b0));
                check("limiter", lim, cmd.general_pin_one);
                check("aux function", auxf, cmd.general_pin_one);
            end
            @(posedge ref_clk_i);
            cmd <= 7'h28;
            settle(6);
            @(posedge ref_clk_i);
            cmd <= 7'h50;
            n = 8'h00;
            repeat (8)
            begin
                @(posedge ref_clk_i);
                #1;
                n = n + {7'h00, conv};
            end
            check("conversion starts", n, (s == 1 || s == 3) ? 8'h01 : 8'h00);
        end
        wr(8'h14, 8'h00);
        @(posedge ref_clk_i);
        rec_on <= 1'b0;
        play_on <= 1'b0;
        settle(6);
        check("record off", rec_off, 8'h01);
        check("playback off", play_off, 8'h01);
        check("limiter off", {lim, auxf}, 8'h00);
        @(posedge ref_clk_i);
        rec_on <= 1'b1;
        play_on <= 1'b1;
        cmd <= 7'h00;
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h14, {m[1], 7'h00});
            wr(8'h13, {2'h3, m[0], !m[0], m[1] ? 4'hf : 4'ha});
            settle(2);
            check("record types", {ch1, ch2}, 8'h03);
            mic({!m[0], m[0], m[0], !m[0]}, 4'hf);
        end
        wr(8'h14, 8'h00);
        wr(8'h13, 8'h4f);
        @(posedge ref_clk_i);
        cmd <= 7'h10;
        settle(6);
        check("record types", {ch1, ch2}, 8'h01);
        mic(4'hf, 4'hf);
        wr(8'h13, 8'h00);
        mic(4'h0, 4'h0);
        report_and_stop();
    end
endmodule // cpr_pin_routing_tb
